// [logic/tcc_params.svh]
// Offsets, field positions, reset values and counts of the capture/compare unit
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_ADDR_W 8
`define TCC_NUM_CH 4
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_STATUS 8'h04
`define TCC_OFS_SOFTGEN 8'h08
`define TCC_OFS_BURST_CFG 8'h0c
`define TCC_OFS_BURST_WIN 8'h10
`define TCC_OFS_CFG0 8'h20
`define TCC_OFS_CV0 8'h30
`define TCC_CTRL_RUN 0
`define TCC_CTRL_HOLD 1
`define TCC_CTRL_ALIGN_LO 2
`define TCC_CTRL_ALIGN_HI 3
`define TCC_CTRL_CDE 4
`define TCC_CTRL_RESET 5'h00
`define TCC_CFG_W 19
`define TCC_CFG_RESET 19'h00000
`define TCC_CV_RESET 16'h0000
`define TCC_BC_START_LO 0
`define TCC_BC_START_HI 4
`define TCC_BC_COUNT_LO 8
`define TCC_BC_COUNT_HI 12
`define TCC_STAT_OVC_LO 4
`define TCC_STAT_OVC_HI 7
`define TCC_ALIGN_DOWN 2'b01
`define TCC_ALIGN_UP 2'b10
`define TCC_ALIGN_BOTH 2'b11
`endif

// [logic/tcc_pkg.sv]
// Types shared by the capture/compare unit
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_MODE_OUTPUT = 2'b00,
        TCC_MODE_OWN = 2'b01,
        TCC_MODE_NEIGHBOUR = 2'b10,
        TCC_MODE_TRIGGER = 2'b11
    } tcc_mode_t;
    typedef enum logic [2:0] {
        TCC_OCC_FROZEN = 3'b000,
        TCC_OCC_SET = 3'b001,
        TCC_OCC_TOGGLE = 3'b010,
        TCC_OCC_CLEAR = 3'b011,
        TCC_OCC_FORCE_LOW = 3'b100,
        TCC_OCC_FORCE_HIGH = 3'b101,
        TCC_OCC_PWM0 = 3'b110,
        TCC_OCC_PWM1 = 3'b111
    } tcc_occ_t;
    typedef enum logic [0:0] {
        TCC_DMA_IDLE = 1'b0,
        TCC_DMA_BUSY = 1'b1
    } tcc_dma_state_t;
    typedef struct packed {
        logic xor_input_select;
        logic channel_dma_enable;
        logic channel_irq_enable;
        logic channel_output_enable;
        logic channel_neg_polarity;
        logic channel_polarity;
        logic compare_clear_enable;
        logic compare_shadow_enable;
        logic [2:0] compare_output_control;
        logic [1:0] capture_prescale;
        logic [3:0] capture_filter_setting;
        logic [1:0] channel_mode_select;
    } tcc_chan_cfg_t;
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] auto_reload_value;
        logic down;
        logic tick;
        logic update_event;
    } tcc_counter_t;
endpackage

// [logic/tcc_channels.sv]
// Four-channel input capture / output compare unit with burst DMA window
`include "tcc_params.svh"

// Contract
// [R1] Selected edge copies counter, sets event flag
// [R2] Raw input: own pin or XOR of 0-2
// [R3] Synchronise, filter, then polarity edge detect
// [R4] Mode picks own, other channel, or trigger
// [R5] Prescaler divides qualified edges into captures
// [R6] Input mode blocks software compare value writes
// [R7] Capture with flag set raises overcapture
// [R8] Soft generate raises interrupt or DMA directly
// [R9] Mode 01 own input, 10 neighbour input
// [R10] Compare match sets, clears or toggles output
// [R11] Match sets flag, interrupt and DMA request
// [R12] Output is prepare xor polarity, enable gated
// [R13] Codes 110/111 generate PWM waveforms
// [R14] Edge aligned: period reload, duty compare
// [R15] Center aligned: period and duty doubled
// [R16] Compare above reload: PWM0 low, PWM1 high; code pins the level only when counting up
// [R17] Match: 000 keep, 001 high, 011 low
// [R18] Codes 100/101 force inactive or active
// [R19] Clear enable: trigger forces low until update
// [R20] Compare rewrites applied per shadow enable
// [R21] Burst window maps to start-index register
// [R22] Each DMA event issues count plus one requests; code drops events that arrive during a burst
// [R23] Debug halt with hold bit stops counter
// [R24] Align mode gates flags by count direction
// [R25] No capture unless enabled; software clears flags
module tcc_channels
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [`TCC_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Counter side
    input wire tcc_counter_t counter_in,
    input wire logic debug_halt_in,
    output logic counter_run_out,
    output logic counter_stop_out,
    // Channel pins and triggers
    input wire logic [`TCC_NUM_CH-1:0] ch_pin_in,
    input wire logic internal_trigger_in,
    input wire logic filtered_ext_trigger_in,
    output logic [`TCC_NUM_CH-1:0] channel_output_pin_signal_out,
    output logic [`TCC_NUM_CH-1:0] channel_output_enable_out,
    // Requests
    output logic [`TCC_NUM_CH-1:0] ch_irq_out,
    output logic dma_req_out
);

    localparam int NCH = `TCC_NUM_CH;

    ////////////////////////////////////////
    // Control registers and address remapping

    logic [4:0] ctrl_ff;
    logic [12:0] burst_cfg_ff;
    logic [4:0] burst_pos_ff;
    logic [5:0] dma_left_ff;
    tcc_dma_state_t dma_state_ff;
    tcc_chan_cfg_t cfg_ff [NCH];
    logic [15:0] cv_ff [NCH];
    logic [NCH-1:0] flag_ff;
    logic [NCH-1:0] ovc_ff;
    logic [NCH-1:0] flag_set;
    logic [NCH-1:0] ovc_set;
    logic [NCH-1:0] dma_evt;
    logic [`TCC_ADDR_W-1:0] eff_addr;
    logic win_hit;
    logic [4:0] win_index;
    logic [31:0] nxt_rdata;
    logic [1:0] align_mode_select;

    assign align_mode_select = ctrl_ff[`TCC_CTRL_ALIGN_HI:`TCC_CTRL_ALIGN_LO];
    assign win_hit = (reg_wr_in || reg_rd_in) && (reg_addr_in == `TCC_OFS_BURST_WIN);
    assign win_index = 5'(burst_cfg_ff[`TCC_BC_START_HI:`TCC_BC_START_LO] + burst_pos_ff);
    // Window maps to start index plus progress
    assign eff_addr = win_hit ? {1'b0, win_index, 2'b00} : reg_addr_in; // [R21]

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ctrl_ff <= `TCC_CTRL_RESET;
        end else if (reg_wr_in && eff_addr == `TCC_OFS_CTRL) begin
            ctrl_ff <= reg_wdata_in[4:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            burst_cfg_ff <= 13'h0000;
        end else if (reg_wr_in && eff_addr == `TCC_OFS_BURST_CFG) begin
            burst_cfg_ff <= {reg_wdata_in[12:8], 3'h0, reg_wdata_in[4:0]};
        end
    end

    // Debug halt with hold set freezes counting
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            counter_stop_out <= 1'b0;
            counter_run_out <= 1'b0;
        end else begin
            counter_stop_out <= debug_halt_in && ctrl_ff[`TCC_CTRL_HOLD]; // [R23]
            counter_run_out <= ctrl_ff[`TCC_CTRL_RUN] &&
                !(debug_halt_in && ctrl_ff[`TCC_CTRL_HOLD]); // [R23]
        end
    end

    ////////////////////////////////////////
    // Input synchronisers and XOR source

    logic [NCH-1:0] pin_meta_ff;
    logic [NCH-1:0] pin_sync_ff;
    logic itrig_prev_ff;
    logic itrig_edge;
    logic xor_012;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end else begin
            pin_meta_ff <= ch_pin_in; // [R3]
            pin_sync_ff <= pin_meta_ff; // [R3]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            itrig_prev_ff <= 1'b0;
        end else begin
            itrig_prev_ff <= internal_trigger_in;
        end
    end

    assign itrig_edge = internal_trigger_in && !itrig_prev_ff;
    assign xor_012 = pin_sync_ff[0] ^ pin_sync_ff[1] ^ pin_sync_ff[2];

    logic [NCH-1:0] filt_ff;
    logic [NCH-1:0] filt_prev_ff;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;

    ////////////////////////////////////////
    // Per-channel logic

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            localparam logic [7:0] CFG_OFS = 8'(`TCC_OFS_CFG0 + 4 * gi);
            localparam logic [7:0] CV_OFS = 8'(`TCC_OFS_CV0 + 4 * gi);
            logic raw_in;
            logic [3:0] filt_cnt_ff;
            logic [2:0] psc_cnt_ff;
            logic [2:0] psc_target;
            logic src_edge;
            logic sel_rise;
            logic sel_fall;
            logic qual_edge;
            logic cap_evt;
            logic capture_mode;
            logic [15:0] cv_act_ff;
            logic eq;
            logic dir_ok;
            logic cmp_evt;
            logic soft_gen;
            logic prep_ff;
            logic clr_hold_ff;
            logic pwm_level;

            assign raw_in = cfg_ff[gi].xor_input_select ? xor_012 : pin_sync_ff[gi]; // [R2]

            // Filter: N+1 differing samples accept a level
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    filt_cnt_ff <= 4'h0;
                    filt_ff[gi] <= 1'b0;
                    filt_prev_ff[gi] <= 1'b0;
                end else begin
                    filt_prev_ff[gi] <= filt_ff[gi];
                    if (raw_in == filt_ff[gi]) begin
                        filt_cnt_ff <= 4'h0;
                    end else if (filt_cnt_ff >= cfg_ff[gi].capture_filter_setting) begin
                        filt_ff[gi] <= raw_in; // [R3]
                        filt_cnt_ff <= 4'h0;
                    end else begin
                        filt_cnt_ff <= 4'(filt_cnt_ff + 4'h1);
                    end
                end
            end

            assign rise[gi] = filt_ff[gi] && !filt_prev_ff[gi];
            assign fall[gi] = !filt_ff[gi] && filt_prev_ff[gi];
            assign capture_mode = cfg_ff[gi].channel_mode_select != TCC_MODE_OUTPUT;

            always_comb begin
                sel_rise = rise[gi];
                sel_fall = fall[gi];
                src_edge = 1'b0;
                case (tcc_mode_t'(cfg_ff[gi].channel_mode_select))
                    TCC_MODE_OWN: begin
                        sel_rise = rise[gi]; // [R9]
                        sel_fall = fall[gi];
                    end
                    TCC_MODE_NEIGHBOUR: begin
                        sel_rise = rise[gi ^ 1]; // [R9]
                        sel_fall = fall[gi ^ 1];
                    end
                    TCC_MODE_TRIGGER: begin
                        src_edge = itrig_edge; // [R4]
                    end
                    default: begin
                        src_edge = 1'b0;
                    end
                endcase
                // Both polarity bits set selects both edges
                if (cfg_ff[gi].channel_mode_select == TCC_MODE_TRIGGER) begin
                    qual_edge = src_edge; // [R4]
                end else if (cfg_ff[gi].channel_polarity && cfg_ff[gi].channel_neg_polarity) begin
                    qual_edge = sel_rise || sel_fall; // [R3]
                end else if (cfg_ff[gi].channel_polarity) begin
                    qual_edge = sel_fall; // [R3]
                end else begin
                    qual_edge = sel_rise; // [R3]
                end
            end

            assign psc_target = 3'((4'h1 << cfg_ff[gi].capture_prescale) - 4'h1);
            assign cap_evt = capture_mode && cfg_ff[gi].channel_output_enable &&
                qual_edge && (psc_cnt_ff == psc_target); // [R25]

            always_ff @(posedge mclk_in) begin
                if (reset_in || !capture_mode || !cfg_ff[gi].channel_output_enable) begin
                    psc_cnt_ff <= 3'h0;
                end else if (qual_edge) begin
                    psc_cnt_ff <= (psc_cnt_ff == psc_target) ? 3'h0 : 3'(psc_cnt_ff + 3'h1); // [R5]
                end
            end

            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    cfg_ff[gi] <= `TCC_CFG_RESET;
                end else if (reg_wr_in && eff_addr == CFG_OFS) begin
                    cfg_ff[gi] <= reg_wdata_in[`TCC_CFG_W-1:0];
                end
            end

            // Capture wins; software writes only in output mode
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    cv_ff[gi] <= `TCC_CV_RESET;
                end else if (cap_evt) begin
                    cv_ff[gi] <= counter_in.count; // [R1]
                end else if (reg_wr_in && eff_addr == CV_OFS && !capture_mode) begin // [R6]
                    cv_ff[gi] <= reg_wdata_in[15:0]; // [R20]
                end
            end

            // Shadowed value loads only at an update event
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    cv_act_ff <= `TCC_CV_RESET;
                end else if (!cfg_ff[gi].compare_shadow_enable || counter_in.update_event) begin
                    cv_act_ff <= cv_ff[gi]; // [R20]
                end
            end

            assign eq = counter_in.count == cv_act_ff;
            always_comb begin
                case (align_mode_select)
                    `TCC_ALIGN_DOWN: dir_ok = counter_in.down; // [R24]
                    `TCC_ALIGN_UP: dir_ok = !counter_in.down; // [R24]
                    `TCC_ALIGN_BOTH: dir_ok = 1'b1; // [R24]
                    default: dir_ok = 1'b1;
                endcase
            end
            assign cmp_evt = !capture_mode && counter_in.tick && eq && dir_ok; // [R11]
            assign soft_gen = reg_wr_in && eff_addr == `TCC_OFS_SOFTGEN && reg_wdata_in[gi];

            assign flag_set[gi] = cap_evt || cmp_evt || soft_gen; // [R1] [R11] [R8]
            assign ovc_set[gi] = cap_evt && flag_ff[gi]; // [R7]
            assign dma_evt[gi] = (cap_evt && cfg_ff[gi].channel_dma_enable) ||
                (cmp_evt && ctrl_ff[`TCC_CTRL_CDE]) ||
                (soft_gen && cfg_ff[gi].channel_dma_enable); // [R11] [R8]

            // Up counting with compare beyond reload pins the PWM level
            always_comb begin
                if (!counter_in.down && cv_act_ff > counter_in.auto_reload_value) begin
                    pwm_level = 1'b0; // [R16]
                end else begin
                    // Counter sweep sets period and duty
                    pwm_level = counter_in.count < cv_act_ff; // [R13] [R14] [R15]
                end
            end

            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    clr_hold_ff <= 1'b0;
                end else if (cfg_ff[gi].compare_clear_enable && filtered_ext_trigger_in) begin
                    clr_hold_ff <= 1'b1; // [R19]
                end else if (counter_in.update_event || !cfg_ff[gi].compare_clear_enable) begin
                    clr_hold_ff <= 1'b0; // [R19]
                end
            end

            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    prep_ff <= 1'b0;
                end else if (clr_hold_ff || (cfg_ff[gi].compare_clear_enable &&
                        filtered_ext_trigger_in)) begin
                    prep_ff <= 1'b0; // [R19]
                end else begin
                    case (tcc_occ_t'(cfg_ff[gi].compare_output_control))
                        TCC_OCC_FROZEN: prep_ff <= prep_ff; // [R17]
                        TCC_OCC_SET: begin
                            if (counter_in.tick && eq) begin
                                prep_ff <= 1'b1; // [R17] [R10]
                            end
                        end
                        TCC_OCC_TOGGLE: begin
                            if (counter_in.tick && eq) begin
                                prep_ff <= !prep_ff; // [R10]
                            end
                        end
                        TCC_OCC_CLEAR: begin
                            if (counter_in.tick && eq) begin
                                prep_ff <= 1'b0; // [R17] [R10]
                            end
                        end
                        TCC_OCC_FORCE_LOW: prep_ff <= 1'b0; // [R18]
                        TCC_OCC_FORCE_HIGH: prep_ff <= 1'b1; // [R18]
                        TCC_OCC_PWM0: prep_ff <= pwm_level; // [R13]
                        TCC_OCC_PWM1: prep_ff <= !pwm_level; // [R13] [R16]
                        default: prep_ff <= prep_ff;
                    endcase
                end
            end

            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    channel_output_pin_signal_out[gi] <= 1'b0;
                    channel_output_enable_out[gi] <= 1'b0;
                end else begin
                    channel_output_pin_signal_out[gi] <= (prep_ff ^ cfg_ff[gi].channel_polarity) &&
                        cfg_ff[gi].channel_output_enable && !capture_mode; // [R12]
                    channel_output_enable_out[gi] <= cfg_ff[gi].channel_output_enable &&
                        !capture_mode; // [R12]
                end
            end

            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    ch_irq_out[gi] <= 1'b0;
                end else begin
                    ch_irq_out[gi] <= flag_ff[gi] && cfg_ff[gi].channel_irq_enable; // [R1] [R11]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////
    // Flags: write one to clear, a new event in the same cycle wins

    logic status_wr;
    assign status_wr = reg_wr_in && eff_addr == `TCC_OFS_STATUS;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            flag_ff <= 4'h0;
            ovc_ff <= 4'h0;
        end else begin
            flag_ff <= (flag_ff & ~(status_wr ? reg_wdata_in[3:0] : 4'h0)) | flag_set; // [R25]
            ovc_ff <= (ovc_ff & ~(status_wr ?
                reg_wdata_in[`TCC_STAT_OVC_HI:`TCC_STAT_OVC_LO] : 4'h0)) | ovc_set; // [R7]
        end
    end

    ////////////////////////////////////////
    // Burst DMA; events during a burst are dropped

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            dma_state_ff <= TCC_DMA_IDLE;
            dma_left_ff <= 6'h00;
            burst_pos_ff <= 5'h00;
        end else begin
            case (dma_state_ff)
                TCC_DMA_IDLE: begin
                    burst_pos_ff <= 5'h00;
                    if (|dma_evt) begin
                        dma_left_ff <= 6'({1'b0, burst_cfg_ff[`TCC_BC_COUNT_HI:`TCC_BC_COUNT_LO]}
                            + 6'h01); // [R22]
                        dma_state_ff <= TCC_DMA_BUSY;
                    end
                end
                TCC_DMA_BUSY: begin
                    if (win_hit) begin
                        dma_left_ff <= 6'(dma_left_ff - 6'h01); // [R22]
                        burst_pos_ff <= 5'(burst_pos_ff + 5'h01);
                        if (dma_left_ff == 6'h01) begin
                            dma_state_ff <= TCC_DMA_IDLE;
                        end
                    end
                end
                default: dma_state_ff <= TCC_DMA_IDLE;
            endcase
        end
    end

    // Request drops after the serving window access
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            dma_req_out <= 1'b0;
        end else begin
            dma_req_out <= (dma_state_ff == TCC_DMA_BUSY) &&
                !win_hit; // [R22]
        end
    end

    ////////////////////////////////////////
    // Read path

    always_comb begin
        nxt_rdata = '0;
        if (eff_addr == `TCC_OFS_CTRL) begin
            nxt_rdata = {27'h0, ctrl_ff};
        end else if (eff_addr == `TCC_OFS_STATUS) begin
            nxt_rdata = {24'h0, ovc_ff, flag_ff};
        end else if (eff_addr == `TCC_OFS_BURST_CFG) begin
            nxt_rdata = {19'h0, burst_cfg_ff};
        end else if (eff_addr[7:4] == `TCC_OFS_CFG0 >> 4) begin
            nxt_rdata = {13'h0, cfg_ff[eff_addr[3:2]]};
        end else if (eff_addr[7:4] == `TCC_OFS_CV0 >> 4) begin
            nxt_rdata = {16'h0, cv_ff[eff_addr[3:2]]};
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= nxt_rdata;
        end else begin
            reg_rdata_out <= '0;
        end
    end

endmodule

// [test/tcc_channels_checker.sv]
// Port assertions of the capture/compare unit
module tcc_channels_checker (
    // Clock, reset and bus
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Watched signals
    input wire logic debug_halt_in,
    input wire logic counter_run_out,
    input wire logic counter_stop_out,
    input wire logic [3:0] channel_output_pin_signal_out,
    input wire logic [3:0] channel_output_enable_out,
    input wire logic [3:0] ch_irq_out,
    input wire logic dma_req_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    wire logic win = (reg_rd_in || reg_wr_in) && reg_addr_in == 8'h10;
    rd_idle_a: assert property (
        !$past(reg_rd_in) || $past(reg_addr_in) == 8'h08 |-> reg_rdata_out == 32'h0)
        else $error("read data outside slot");
    pin_gate_a: assert property (
        (channel_output_pin_signal_out & ~channel_output_enable_out) == 4'h0)
        else $error("pin driven while disabled");
    oe_hold_a: assert property (
        !$past(reset_in) && !$past(reg_wr_in) && !$past(reg_wr_in, 2)
        |-> $stable(channel_output_enable_out)) else $error("enable moved alone");
    halt_stop_a: assert property (
        counter_stop_out |-> $past(debug_halt_in) && !counter_run_out)
        else $error("stop without halt");
    run_move_a: assert property (
        $changed(counter_run_out) |-> $past(reg_wr_in, 2) || $past(reset_in)
        || $past(debug_halt_in) != $past(debug_halt_in, 2)) else $error("run moved alone");
    dma_hold_a: assert property (dma_req_out && !win |=> dma_req_out)
        else $error("request dropped early");
    dma_drop_a: assert property (dma_req_out && win |=> !dma_req_out)
        else $error("request kept after access");
    irq_fall_a: assert property (
        |($past(ch_irq_out) & ~ch_irq_out) |-> $past(reg_wr_in, 2) || $past(reset_in))
        else $error("flag cleared without write");
    cover property ($rose(dma_req_out));
    cover property ($rose(|ch_irq_out));
    cover property (counter_stop_out);
endmodule
bind tcc_channels tcc_channels_checker tcc_channels_checker_inst (.*);

// [test/tcc_far_side.sv]
// DMA controller model: one window read per request
module tcc_far_side (
    // Clock, request and delay
    input wire logic mclk_in,
    input wire logic dma_req_in,
    input wire logic [3:0] delay_in,
    // Window strobe and tally
    output logic win_rd_out = 1'b0,
    output logic [7:0] served_out = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt = 4'h0;
    // One-cycle strobe: a stale request is never served twice
    always @(posedge mclk_in) begin
        if (win_rd_out) begin
            win_rd_out <= 1'b0;
            served_out <= served_out + 8'h01;
        end else if (dma_req_in && wait_cnt >= delay_in) begin
            win_rd_out <= 1'b1;
            wait_cnt <= 4'h0;
        end else if (dma_req_in) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// [test/tcc_channels_bench.sv]
// Self-checking bench of the capture/compare unit
module tcc_channels_bench
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcc_row_t;
    typedef struct {logic [2:0] o; logic [15:0] c; logic [15:0] r; logic e;} tcc_cmp_t;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr_s = 1'b0, rd_s = 1'b0, halt = 1'b0, trig = 1'b0, run, stop, dma, p_rd;
    logic [7:0] addr = 8'h00, served, n0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] pins = 4'h0, dly = 4'h0, pin_o, oe_o, irq;
    tcc_counter_t cnt = '0;
    int error_cnt = 0, check_count = 0;
    tcc_row_t rows[12] = '{'{8'h00, '1, 32'h1f}, '{8'h00, 32'h0, 32'h0},
        '{8'h0c, '1, 32'h1f1f}, '{8'h0c, 32'h3, 32'h3}, '{8'h10, 32'h3, 32'h3},
        '{8'h30, 32'habcd, 32'habcd}, '{8'h20, 32'h1, 32'h1}, '{8'h30, 32'h1234, 32'habcd},
        '{8'h08, 32'h2, 32'h0}, '{8'h04, 32'h0, 32'h2}, '{8'h04, 32'hf, 32'h0},
        '{8'hfc, '1, 32'h0}};
    tcc_row_t cap[4] = '{'{8'h30, 32'h0, 32'h789}, '{8'h34, 32'h0, 32'h456},
        '{8'h38, 32'h0, 32'haaa}, '{8'h04, 32'h0, 32'h17}};
    tcc_cmp_t cmp[10] = '{'{3'h1, 16'h5, 16'h14, 1'b1}, '{3'h0, 16'h5, 16'h14, 1'b1},
        '{3'h3, 16'h5, 16'h14, 1'b0}, '{3'h2, 16'h5, 16'h14, 1'b1},
        '{3'h4, 16'h9, 16'h14, 1'b0}, '{3'h5, 16'h9, 16'h14, 1'b1},
        '{3'h6, 16'h6, 16'h14, 1'b0}, '{3'h7, 16'h2, 16'h14, 1'b0},
        '{3'h6, 16'h2, 16'h3, 1'b0}, '{3'h7, 16'h2, 16'h3, 1'b1}};
    always #50 mclk_in = ~mclk_in;
    tcc_channels tcc_channels_inst (.mclk_in(mclk_in), .reset_in(reset_in),
        .reg_addr_in(p_rd ? 8'h10 : addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s | p_rd), .reg_rdata_out(rdata), .counter_in(cnt),
        .debug_halt_in(halt), .counter_run_out(run), .counter_stop_out(stop),
        .ch_pin_in(pins), .internal_trigger_in(trig), .filtered_ext_trigger_in(1'b0),
        .channel_output_pin_signal_out(pin_o), .channel_output_enable_out(oe_o),
        .ch_irq_out(irq), .dma_req_out(dma));
    tcc_far_side tcc_far_side_inst (.mclk_in(mclk_in), .dma_req_in(dma), .delay_in(dly),
        .win_rd_out(p_rd), .served_out(served));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge mclk_in);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk_in);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Count value is held, tick lasts one cycle
    task automatic step(input logic [3:0] p, input tcc_counter_t c, input int n);
        @(posedge mclk_in);
        pins <= p;
        cnt <= c;
        @(posedge mclk_in);
        cnt.tick <= 1'b0;
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic final_report();
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_in <= 1'b0;
        step(4'h0, '0, 1);
        check("reset outputs", 32'h0, {pin_o, oe_o, irq, run, stop, dma});
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check("register", rows[i].e, d);
        end
        wr(8'h20, 32'h18001);
        wr(8'h24, 32'ha002);
        step(4'h1, {16'h0123, 19'h0}, 10);
        check("capture irq", 32'h1, irq);
        step(4'h0, {16'h0456, 19'h0}, 10);
        wr(8'h28, 32'h48001);
        step(4'h2, {16'h0aaa, 19'h0}, 10);
        step(4'h3, {16'h0789, 19'h0}, 10);
        foreach (cap[i]) begin
            rd(cap[i].a);
            check("capture", cap[i].e, d);
        end
        wr(8'h24, 32'h8100);
        wr(8'h34, 32'h5);
        foreach (cmp[i]) begin
            wr(8'h24, 32'h8000 | {cmp[i].o, 8'h00});
            step(4'h3, {cmp[i].c, cmp[i].r, 3'h2}, 3);
            check("compare pin", cmp[i].e, pin_o[1]);
        end
        wr(8'h24, 32'ha100);
        step(4'h3, cnt, 2);
        check("polarity", 32'h1, {pin_o[1], oe_o[1]});
        wr(8'h00, 32'h3);
        halt <= 1'b1;
        step(4'h3, cnt, 2);
        check("halted", 32'h1, {run, stop});
        halt <= 1'b0;
        step(4'h3, cnt, 2);
        check("running", 32'h2, {run, stop});
        wr(8'h2c, 32'h8003);
        step(4'h3, {16'h0321, 19'h0}, 0);
        trig <= 1'b1;
        step(4'h3, cnt, 1);
        rd(8'h3c);
        check("trigger capture", 32'h321, d);
        wr(8'h00, 32'h0);
        wr(8'h28, 32'h20000);
        for (int i = 0; i < 2; i++) begin
            n0 = served;
            dly <= 4'(5 * i);
            wr(8'h0c, 32'(i * 3) << 8);
            wr(8'h08, 32'h4);
            repeat (60) @(posedge mclk_in);
            check("dma requests", 32'(i * 3 + 1), 32'(served - n0));
        end
        final_report();
    end
endmodule
